// ==== core/mvw_store_defines.vh ====
// Purpose: shared constants for the multi-vector word store decoder
// Assumes: included by the decode and address generation file by bare name
// Notes:   definitions only
`ifndef MVW_STORE_DEFINES_VH
`define MVW_STORE_DEFINES_VH

`define MVW_ELEM_BITS        32
`define MVW_BYTE_BITS        8
`define MVW_ELEM_BYTES       4'h4
`define MVW_ELEM_SHIFT       5
`define MVW_SP_INDEX         5'h1F
`define MVW_SP_ALIGN_MASK    64'h000000000000000F
`define MVW_PRED_BANK_HIGH   1'b1
`define MVW_STRIDE_TWO       5'h08
`define MVW_STRIDE_FOUR      5'h04
`define MVW_CHECK_SP_NONE    1'b1
`define MVW_FIFO_DEPTH       8
`define MVW_FIFO_ADDR_BITS   3
`define MVW_FIFO_WIDTH       97
`define MVW_VL_BITS          12

`endif

// ==== core/mvw_store_fifo.v ====
// Purpose: store transaction buffer between decoder and memory side
// Assumes: one clock, synchronous active-low reset
// Notes:   first-word fall-through; full and empty are exact
`timescale 1ns/1ps
module mvw_store_fifo #(
  parameter WIDTH = 97,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             i_clock,
  input  wire             i_rst_b,
  // fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] store_mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;
  wire            push;
  wire            pop;

  assign o_in_ready  = (fill != DEPTH[AW:0]);
  assign o_out_valid = (fill != {(AW+1){1'b0}});
  assign o_out_data  = store_mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always @(posedge i_clock) begin
    if (push) begin
      store_mem[wr_ptr] <= i_in_data;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        fill <= fill + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        fill <= fill - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== core/mvw_multi_vector_word_store_agu.v ====
// Purpose: decode and address generation for the multi_vector_word_store
//          forms: two or four vectors, consecutive or strided groups,
//          immediate or scalar index, predicate-as-counter masking
// Assumes: register file read ports answer combinationally in the cycle
//          the index is presented; inputs share i_clock
// Notes:   stores leave through an 8-entry buffer
`timescale 1ns/1ps
`include "mvw_store_defines.vh"
module mvw_multi_vector_word_store_agu (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst_b,
  // instruction issue
  input  wire        i_issue_valid,
  output wire        o_issue_ready,
  input  wire        i_four_regs,
  input  wire        i_strided,
  input  wire        i_scalar_index,
  input  wire [3:0]  i_vector_register_field,
  input  wire        i_stride_high,
  input  wire [2:0]  i_counter_predicate_field,
  input  wire [4:0]  i_base_register_field,
  input  wire [4:0]  i_offset_register_field,
  input  wire [3:0]  i_vector_offset_immediate,
  // processor state
  input  wire        i_streaming_enabled,
  input  wire [11:0] i_vector_length,
  input  wire [63:0] i_stack_pointer,
  // general-purpose register read ports
  output wire [4:0]  o_base_read_index,
  input  wire [63:0] i_base_read_data,
  output wire [4:0]  o_offset_read_index,
  input  wire [63:0] i_offset_read_data,
  // predicate register read port
  output wire [3:0]  o_pred_read_index,
  input  wire [15:0] i_pred_read_data,
  // vector register element read port
  output wire [4:0]  o_vec_read_index,
  output wire [5:0]  o_vec_read_element,
  input  wire [31:0] i_vec_read_data,
  // store transactions to memory
  output wire        o_store_valid,
  input  wire        i_store_ready,
  output wire [63:0] o_store_addr,
  output wire [31:0] o_store_data,
  output wire        o_store_tag_checked,
  output wire [3:0]  o_store_size_bytes,
  output wire        o_store_contiguous,
  output wire        o_store_nontemporal,
  // status
  output wire        o_busy,
  output reg         o_done,
  output reg         o_fault_not_streaming,
  output reg         o_fault_sp_align,
  output reg  [7:0]  o_decoded_vector_offset
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_CHECK = 3'b010;
  localparam ST_RUN   = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;

  // instruction held for the whole operation
  reg         four_regs;
  reg         strided;
  reg         scalar_index;
  reg  [3:0]  vfield;
  reg         stride_high;
  reg  [2:0]  pfield;
  reg  [4:0]  nfield;
  reg  [4:0]  mfield;
  reg  [3:0]  imm;
  reg  [6:0]  elems;

  // expanded predicate and walk state
  reg  [1:0]  mask_shift;
  reg  [10:0] mask_count;
  reg  [10:0] mask_first;
  reg         mask_invert;
  reg         mask_none;
  reg  [8:0]  total;
  reg  [8:0]  gidx;
  reg  [6:0]  eidx;
  reg  [1:0]  ridx;
  reg  [63:0] base;
  reg  [63:0] index;
  reg         tag_checked;

  wire        issue;
  wire        base_is_sp;
  wire [1:0]  pred_shift;
  wire [2:0]  pred_shift_p1;
  wire [14:0] pred_count;
  wire        pred_zero;
  wire [8:0]  total_now;
  wire [10:0] total_pe;
  wire [10:0] cap_count;
  wire [10:0] last_pe;
  wire        any_active;
  wire        sp_misaligned;
  wire [63:0] imm_sx;
  wire [63:0] imm_group;
  wire [63:0] imm_start;
  wire [4:0]  first_reg;
  wire [4:0]  reg_step;
  wire [10:0] elem_pe;
  wire        elem_active;
  wire        fifo_in_ready;
  wire        push;
  wire        advance;
  wire        last_elem;
  wire [63:0] elem_addr;
  wire [96:0] fifo_in;
  wire [96:0] fifo_out;

  assign issue         = i_issue_valid && (state == ST_IDLE);
  assign o_issue_ready = (state == ST_IDLE);
  assign o_busy        = (state != ST_IDLE);

  // read ports steered by the held fields
  assign base_is_sp          = (nfield == `MVW_SP_INDEX);
  assign o_base_read_index   = nfield;
  assign o_offset_read_index = mfield;
  assign o_pred_read_index   = {`MVW_PRED_BANK_HIGH, pfield};

  // counter decode: lowest set bit of 3:0 gives the element size
  assign pred_shift = i_pred_read_data[0] ? 2'h0 :
                      i_pred_read_data[1] ? 2'h1 :
                      i_pred_read_data[2] ? 2'h2 : 2'h3;
  assign pred_shift_p1 = {1'b0, pred_shift} + 3'h1;
  assign pred_count    = i_pred_read_data[14:0] >> pred_shift_p1;
  assign pred_zero     = (i_pred_read_data[3:0] == 4'h0);

  // group size in words, and in predicate elements
  assign total_now = four_regs ? {elems, 2'b00}
                               : {1'b0, elems, 1'b0};
  assign total_pe  = {total_now, 2'b00} >> pred_shift;
  assign cap_count = (pred_count > {4'h0, total_pe}) ? total_pe
                                                     : pred_count[10:0];
  assign last_pe   = {total_now - 9'h001, 2'b00} >> pred_shift;
  // inverted counters light the top of the group, plain ones the bottom
  assign any_active = !pred_zero &&
                      (i_pred_read_data[15] ?
                       (last_pe >= total_pe - cap_count) :
                       (cap_count != 11'h000));
  assign sp_misaligned =
    ((i_stack_pointer & `MVW_SP_ALIGN_MASK) != 64'h0);

  // immediate scaled by group size, independent of the mask
  assign imm_sx    = {{60{imm[3]}}, imm};
  assign imm_group = four_regs ? {imm_sx[61:0], 2'b00}
                               : {imm_sx[62:0], 1'b0};
  assign imm_start = imm_group * {57'h0, elems};

  // register numbering per grouping
  assign first_reg =
    strided ? (four_regs ? {stride_high, 2'b00, vfield[1:0]}
                         : {stride_high, 1'b0, vfield[2:0]})
            : (four_regs ? {vfield[2:0], 2'b00}
                         : {vfield, 1'b0});
  assign reg_step =
    strided ? (four_regs ? {1'b0, ridx, 2'b00}
                         : {ridx, 3'b000})
            : {3'b000, ridx};
  assign o_vec_read_index   = first_reg + reg_step;
  assign o_vec_read_element = eidx[5:0];

  // per-element predicate test at word granularity
  assign elem_pe     = {gidx, 2'b00} >> mask_shift;
  assign elem_active = !mask_none &&
                       (mask_invert ? (elem_pe >= mask_first)
                                    : (elem_pe < mask_count));

  assign push      = (state == ST_RUN) && elem_active;
  assign advance   = (state == ST_RUN) && (!elem_active || fifo_in_ready);
  assign last_elem = (gidx == total - 9'h001);
  assign elem_addr = base + {index[61:0], 2'b00};
  assign fifo_in   = {tag_checked, elem_addr, i_vec_read_data};

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (issue && i_streaming_enabled) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (base_is_sp && sp_misaligned &&
            (any_active || `MVW_CHECK_SP_NONE)) begin
          next_state = ST_IDLE;
        end else if (!any_active) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (advance && last_elem) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // capture the instruction on issue
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      four_regs               <= 1'b0;
      strided                 <= 1'b0;
      scalar_index            <= 1'b0;
      vfield                  <= 4'h0;
      stride_high             <= 1'b0;
      pfield                  <= 3'h0;
      nfield                  <= 5'h00;
      mfield                  <= 5'h00;
      imm                     <= 4'h0;
      elems                   <= 7'h00;
      o_decoded_vector_offset <= 8'h00;
    end else if (issue) begin
      four_regs    <= i_four_regs;
      strided      <= i_strided;
      scalar_index <= i_scalar_index;
      vfield       <= i_vector_register_field;
      stride_high  <= i_stride_high;
      pfield       <= i_counter_predicate_field;
      nfield       <= i_base_register_field;
      mfield       <= i_offset_register_field;
      // scalar forms ignore the immediate; default offset is zero
      imm          <= i_scalar_index ? 4'h0 : i_vector_offset_immediate;
      elems        <= i_vector_length[`MVW_VL_BITS-1:`MVW_ELEM_SHIFT];
      if (i_scalar_index) begin
        o_decoded_vector_offset <= 8'h00;
      end else if (i_four_regs) begin
        o_decoded_vector_offset <= {{2{i_vector_offset_immediate[3]}},
                                    i_vector_offset_immediate, 2'b00};
      end else begin
        o_decoded_vector_offset <= {{3{i_vector_offset_immediate[3]}},
                                    i_vector_offset_immediate, 1'b0};
      end
    end
  end

  // predicate expansion, base and start index latched once
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      mask_shift  <= 2'h0;
      mask_count  <= 11'h000;
      mask_first  <= 11'h000;
      mask_invert <= 1'b0;
      mask_none   <= 1'b1;
      total       <= 9'h000;
      base        <= 64'h0;
      tag_checked <= 1'b0;
    end else if (state == ST_CHECK) begin
      mask_shift  <= pred_shift;
      mask_count  <= cap_count;
      mask_first  <= total_pe - cap_count;
      mask_invert <= i_pred_read_data[15];
      mask_none   <= pred_zero;
      total       <= total_now;
      base        <= base_is_sp ? i_stack_pointer
                                : i_base_read_data;
      tag_checked <= scalar_index || !base_is_sp;
    end
  end

  // element walk: registers ascending, elements ascending within each
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      gidx  <= 9'h000;
      eidx  <= 7'h00;
      ridx  <= 2'h0;
      index <= 64'h0;
    end else if (state == ST_CHECK) begin
      gidx  <= 9'h000;
      eidx  <= 7'h00;
      ridx  <= 2'h0;
      // only the local copy steps; the offset register is never written
      index <= scalar_index ? i_offset_read_data : imm_start;
    end else if (advance) begin
      gidx  <= gidx + 9'h001;
      index <= index + 64'h1;
      if (eidx == elems - 7'h01) begin
        eidx <= 7'h00;
        ridx <= ridx + 2'h1;
      end else begin
        eidx <= eidx + 7'h01;
      end
    end
  end

  // one-cycle status pulses
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_done                <= 1'b0;
      o_fault_not_streaming <= 1'b0;
      o_fault_sp_align      <= 1'b0;
    end else begin
      o_fault_not_streaming <= issue && !i_streaming_enabled;
      o_fault_sp_align      <= (state == ST_CHECK) && base_is_sp &&
                               sp_misaligned &&
                               (any_active || `MVW_CHECK_SP_NONE);
      o_done <= ((state == ST_CHECK) && !any_active &&
                 !(base_is_sp && sp_misaligned)) ||
                (advance && last_elem);
    end
  end

  // buffer decouples the walk from memory back-pressure
  mvw_store_fifo #(
    .WIDTH (`MVW_FIFO_WIDTH),
    .DEPTH (`MVW_FIFO_DEPTH),
    .AW    (`MVW_FIFO_ADDR_BITS)
  ) u_store_fifo (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (o_store_valid),
    .i_out_ready (i_store_ready),
    .o_out_data  (fifo_out)
  );

  assign o_store_data        = fifo_out[31:0];
  assign o_store_addr        = fifo_out[95:32];
  assign o_store_tag_checked = fifo_out[96];
  assign o_store_size_bytes  = `MVW_ELEM_BYTES;
  assign o_store_contiguous  = 1'b1;
  assign o_store_nontemporal = 1'b0;
endmodule

// ==== verif/mvw_store_sva.sv ====
// Purpose: port checker for the word store decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the top module by port name
`timescale 1ns/1ps
module mvw_store_sva (
  input wire        i_clock,
  input wire        i_rst_b,
  input wire        i_issue_valid,
  input wire        o_issue_ready,
  input wire        i_four_regs,
  input wire        i_scalar_index,
  input wire [2:0]  i_counter_predicate_field,
  input wire [4:0]  i_base_register_field,
  input wire [4:0]  i_offset_register_field,
  input wire [3:0]  i_vector_offset_immediate,
  input wire        i_streaming_enabled,
  input wire [63:0] i_stack_pointer,
  input wire [4:0]  o_base_read_index,
  input wire [4:0]  o_offset_read_index,
  input wire [3:0]  o_pred_read_index,
  input wire        o_store_valid,
  input wire        i_store_ready,
  input wire [63:0] o_store_addr,
  input wire [31:0] o_store_data,
  input wire [3:0]  o_store_size_bytes,
  input wire        o_store_contiguous,
  input wire        o_store_nontemporal,
  input wire        o_fault_not_streaming,
  input wire        o_fault_sp_align,
  input wire [7:0]  o_decoded_vector_offset
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire take = i_issue_valid && o_issue_ready;
  wire go   = take && i_streaming_enabled;

  size_word_a: assert property (
    o_store_valid |-> o_store_size_bytes == 4'h4)
    else $error("store size is not four bytes");
  store_kind_a: assert property (
    o_store_valid |-> o_store_contiguous && !o_store_nontemporal)
    else $error("store not marked contiguous and temporal");
  pred_bank_a: assert property (
    go |=> o_pred_read_index == {1'b1, $past(i_counter_predicate_field)})
    else $error("predicate read outside the upper bank");
  base_index_a: assert property (
    go |=> o_base_read_index == $past(i_base_register_field))
    else $error("base read index differs from field");
  offset_index_a: assert property (
    go && i_scalar_index |=>
      o_offset_read_index == $past(i_offset_register_field))
    else $error("offset read index differs from field");
  stream_fault_a: assert property (
    take |=> o_fault_not_streaming == !$past(i_streaming_enabled))
    else $error("streaming fault does not follow mode");
  imm_four_a: assert property (
    go && i_four_regs && !i_scalar_index |=> o_decoded_vector_offset ==
      {{2{$past(i_vector_offset_immediate[3])}},
       $past(i_vector_offset_immediate), 2'b00})
    else $error("four vector offset wrongly scaled");
  imm_two_a: assert property (
    go && !i_four_regs && !i_scalar_index |=> o_decoded_vector_offset ==
      {{3{$past(i_vector_offset_immediate[3])}},
       $past(i_vector_offset_immediate), 1'b0})
    else $error("two vector offset wrongly scaled");
  sp_align_a: assert property (
    go && i_base_register_field == 5'h1F ##1
      i_stack_pointer[3:0] != 4'h0 |=> o_fault_sp_align)
    else $error("misaligned stack pointer not flagged");
  head_hold_a: assert property (
    o_store_valid && !i_store_ready |=> o_store_valid &&
      $stable(o_store_addr) && $stable(o_store_data))
    else $error("stalled store changed before taken");
endmodule

bind mvw_multi_vector_word_store_agu mvw_store_sva u_mvw_store_sva (
  .i_clock, .i_rst_b, .i_issue_valid, .o_issue_ready, .i_four_regs,
  .i_scalar_index, .i_counter_predicate_field, .i_base_register_field,
  .i_offset_register_field, .i_vector_offset_immediate,
  .i_streaming_enabled, .i_stack_pointer, .o_base_read_index,
  .o_offset_read_index, .o_pred_read_index, .o_store_valid,
  .i_store_ready, .o_store_addr, .o_store_data, .o_store_size_bytes,
  .o_store_contiguous, .o_store_nontemporal, .o_fault_not_streaming,
  .o_fault_sp_align, .o_decoded_vector_offset
);

// ==== verif/mvw_mem_model.sv ====
// Purpose: memory side stand-in that accepts store words
// Assumes: one clock, synchronous active-low reset
// Notes:   slow mode takes one word in eight so the buffer backs up
`timescale 1ns/1ps
module mvw_mem_model (
  // clock and reset
  input  wire i_clock,
  input  wire i_rst_b,
  // pacing and acceptance
  input  wire i_slow,
  output reg  o_store_ready
);
  reg [2:0] pace;
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      pace          <= 3'h0;
      o_store_ready <= 1'b0;
    end else begin
      pace          <= pace + 3'h1;
      o_store_ready <= !i_slow || (pace == 3'h7);
    end
  end
endmodule

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the word store decoder
// Assumes: register file answers are combinational patterns
// Notes:   expected stores are queued before each issue
`timescale 1ns/1ps
module tb;
  reg         i_clock = 1'b0;
  reg         i_rst_b = 1'b0;
  reg         i_issue_valid = 1'b0;
  reg         i_four_regs = 1'b0;
  reg         i_strided = 1'b0;
  reg         i_scalar_index = 1'b0;
  reg  [3:0]  i_vector_register_field = 4'h0;
  reg         i_stride_high = 1'b0;
  reg  [2:0]  i_counter_predicate_field = 3'h0;
  reg  [4:0]  i_base_register_field = 5'h00;
  reg  [4:0]  i_offset_register_field = 5'h00;
  reg  [3:0]  i_vector_offset_immediate = 4'h0;
  reg         i_streaming_enabled = 1'b0;
  reg  [11:0] i_vector_length = 12'h080;
  reg  [63:0] i_stack_pointer = 64'h0;
  reg  [15:0] pred_val = 16'h0000;
  reg         slow = 1'b0;
  wire        o_issue_ready, i_store_ready, o_store_valid;
  wire        o_store_tag_checked, o_store_contiguous, o_store_nontemporal;
  wire        o_busy, o_done, o_fault_not_streaming, o_fault_sp_align;
  wire [4:0]  o_base_read_index, o_offset_read_index, o_vec_read_index;
  wire [3:0]  o_pred_read_index, o_store_size_bytes;
  wire [5:0]  o_vec_read_element;
  wire [7:0]  o_decoded_vector_offset;
  wire [63:0] o_store_addr, i_base_read_data, i_offset_read_data;
  wire [31:0] o_store_data, i_vec_read_data;
  wire [15:0] i_pred_read_data;
  integer     err_total = 0;
  integer     n_checks = 0;
  logic [96:0] q[$];
  logic [96:0] w;

  // distinct per-index patterns so a wrong index shows as a wrong value
  assign i_base_read_data   = {8'h40, 43'h0, o_base_read_index, 8'h00};
  assign i_offset_read_data = {56'h0, o_offset_read_index, 3'h3};
  assign i_pred_read_data   =
    (o_pred_read_index == {1'b1, i_counter_predicate_field}) ? pred_val
                                                              : 16'h0;
  assign i_vec_read_data    = {11'h5A5, o_vec_read_index, 10'h0,
                               o_vec_read_element};

  mvw_multi_vector_word_store_agu u_mvw_multi_vector_word_store_agu (
    .i_clock, .i_rst_b, .i_issue_valid, .o_issue_ready, .i_four_regs,
    .i_strided, .i_scalar_index, .i_vector_register_field, .i_stride_high,
    .i_counter_predicate_field, .i_base_register_field,
    .i_offset_register_field, .i_vector_offset_immediate,
    .i_streaming_enabled, .i_vector_length, .i_stack_pointer,
    .o_base_read_index, .i_base_read_data, .o_offset_read_index,
    .i_offset_read_data, .o_pred_read_index, .i_pred_read_data,
    .o_vec_read_index, .o_vec_read_element, .i_vec_read_data,
    .o_store_valid, .i_store_ready, .o_store_addr, .o_store_data,
    .o_store_tag_checked, .o_store_size_bytes, .o_store_contiguous,
    .o_store_nontemporal, .o_busy, .o_done, .o_fault_not_streaming,
    .o_fault_sp_align, .o_decoded_vector_offset
  );
  mvw_mem_model u_mvw_mem_model (
    .i_clock, .i_rst_b, .i_slow(slow), .o_store_ready(i_store_ready)
  );

  initial begin
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [96:0] g, input logic [96:0] x);
    n_checks = n_checks + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, x);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // an unexpected store pops an all-ones word and so mismatches
  // sampled mid-cycle: valid and ready are settled until the taking edge
  always @(negedge i_clock) begin
    if (i_rst_b && o_store_valid && i_store_ready) begin
      w = (q.size() != 0) ? q.pop_front() : {97{1'b1}};
      chk(o_store_addr, w[95:32]);
      chk(o_store_data, w[31:0]);
      chk(o_store_tag_checked, w[96]);
    end
  end

  // nc: 0 normal, 1 streaming off, 2 ends at cycle two without stores
  task automatic op(input logic f4, sd, sc, input logic [3:0] fl,
                    input logic t, input logic [4:0] bf,
                    input logic [3:0] im, input logic [11:0] vl,
                    input logic [15:0] p, input integer nc);
    integer nr, el, cnt, r, e, n, sh, tpe, pe;
    longint g, st;
    logic [4:0] rn;
    logic [63:0] base;
    logic [2:0] fx;
    logic [7:0] xo;
    nr = f4 ? 4 : 2;
    el = vl / 32;
    // counter form: lowest set bit of 3:0 gives the predicate element size
    sh = p[0] ? 0 : p[1] ? 1 : p[2] ? 2 : 3;
    tpe = (nr * el * 4) >> sh;
    cnt = p[14:0] >> (sh + 1);
    if (cnt > tpe) cnt = tpe;
    if (p[3:0] == 4'h0) cnt = 0;
    i_counter_predicate_field = fl[2:0] + 3'h1;
    i_offset_register_field = {1'b0, fl} + 5'h2;
    i_stack_pointer = (nc == 2 && bf == 5'h1F) ? 64'h7FF0_1238
                                               : 64'h7FF0_1230;
    base = (bf == 5'h1F) ? i_stack_pointer : {8'h40, 43'h0, bf, 8'h00};
    st = sc ? longint'(i_offset_register_field) * 8 + 3
            : $signed(im) * nr * el;
    for (r = 0; r < nr; r++) begin
      rn = sd ? (f4 ? {t, r[1:0], fl[1:0]} : {t, r[0], fl[2:0]})
              : 5'((f4 ? {fl[2:0], 2'b00} : {fl, 1'b0}) + r);
      for (e = 0; e < el; e++) begin
        g = r * el + e;
        pe = (r * el + e) * 4 >> sh;
        if ((p[15] ? (pe >= tpe - cnt) : (pe < cnt)) && nc == 0)
          q.push_back({sc | (bf != 5'h1F), base + (st + g) * 4,
                       11'h5A5, rn, 10'h0, 6'(e)});
      end
    end
    i_four_regs = f4;
    i_strided = sd;
    i_scalar_index = sc;
    i_vector_register_field = fl;
    i_stride_high = t;
    i_base_register_field = bf;
    i_vector_offset_immediate = im;
    i_vector_length = vl;
    i_streaming_enabled = (nc != 1);
    pred_val = p;
    i_issue_valid = 1'b1;
    @(posedge i_clock);
    #1 i_issue_valid = 1'b0;
    n = 0;
    while (!(o_done || o_fault_not_streaming || o_fault_sp_align) &&
           n < 400) begin
      @(posedge i_clock);
      #1 n = n + 1;
    end
    if (n >= 400) begin
      err_total = err_total + 1;
      wrap_up();
    end
    if (nc != 0) chk(n + 1, nc);
    fx = (nc == 1) ? 3'b100 : (nc == 2 && bf == 5'h1F) ? 3'b010 : 3'b001;
    chk({o_fault_not_streaming, o_fault_sp_align, o_done}, fx);
    xo = sc ? 8'h0 : 8'($signed(im) * nr);
    if (nc != 1) chk(o_decoded_vector_offset, xo);
    n = 0;
    while (q.size() != 0 && n < 3000) begin
      @(posedge i_clock);
      #1 n = n + 1;
    end
    if (n >= 3000) begin
      err_total = err_total + 1;
      wrap_up();
    end
    repeat (3) @(posedge i_clock);
    #1 chk(o_store_valid | o_busy, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    #1 i_rst_b = 1'b1;
    op(0, 0, 0, 4'hF, 0, 5'h03, 4'h7, 12'd128, 16'h0044, 0);
    slow = 1'b1;
    op(1, 0, 0, 4'h7, 0, 5'h04, 4'h8, 12'd128, 16'h0054, 0);
    slow = 1'b0;
    op(0, 1, 0, 4'hD, 1, 5'h05, 4'hF, 12'd256, 16'h801C, 0);
    op(1, 1, 1, 4'h2, 1, 5'h1F, 4'h0, 12'd128, 16'h7FFC, 0);
    op(1, 1, 0, 4'h3, 0, 5'h1F, 4'h3, 12'd128, 16'h0084, 0);
    op(0, 0, 1, 4'h0, 0, 5'h00, 4'h0, 12'd2048, 16'h002C, 0);
    op(0, 0, 0, 4'h1, 0, 5'h02, 4'h1, 12'd128, 16'h0044, 1);
    op(1, 0, 0, 4'h1, 0, 5'h1F, 4'h0, 12'd128, 16'h0044, 2);
    op(0, 0, 1, 4'h1, 0, 5'h02, 4'h0, 12'd128, 16'h0004, 2);
    op(0, 0, 0, 4'h2, 0, 5'h06, 4'h1, 12'd128, 16'h000B, 0);
    op(1, 1, 0, 4'h1, 1, 5'h07, 4'hE, 12'd128, 16'h8012, 0);
    op(0, 1, 1, 4'h6, 0, 5'h08, 4'h0, 12'd128, 16'h0018, 0);
    wrap_up();
  end
endmodule
